// [core/dpwm_top.sv]
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
`default_nettype none
module dpwm_top
   import dpwm_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [2:0][7:0] timer_count,
   input wire logic [2:0][7:0] timer_period,
   input wire logic [2:0][1:0] timer_phase,
   input wire logic [2:0][1:0] timer_prescale,
   input wire logic [2:0] timer_is_1to1,
   input wire logic [2:0] timer_restart,
   output logic [1:0] pwm_out
);

   dpwm_regs_state_t regs_reg;
   dpwm_regs_state_t regs_next;
   logic [1:0] out_level;
   logic req;
   logic commit;
   logic [7:0] wdat;

   // address decode and per channel select
   logic [6:0] hit;
   logic mapped;
   logic rd_take;
   logic [1:0][1:0] chan_sel;

   ////////////////////////////////////////////////////////////////////////////
   // read value of one register, unmapped and reserved bits as zero
   function automatic logic [7:0] read_mux(
      input logic [7:0] adr,
      input dpwm_regs_state_t r,
      input logic [1:0] lvl);
      logic [7:0] v;
      v = 8'h00;
      unique case (adr)
         DPWM_OFS_CTRL0: begin
            v[DPWM_CTRL_EN_BIT] = r.en[0];
            v[DPWM_CTRL_OUT_BIT] = lvl[0];
            v[DPWM_CTRL_POL_BIT] = r.pol[0];
         end
         DPWM_OFS_CTRL1: begin
            v[DPWM_CTRL_EN_BIT] = r.en[1];
            v[DPWM_CTRL_OUT_BIT] = lvl[1];
            v[DPWM_CTRL_POL_BIT] = r.pol[1];
         end
         DPWM_OFS_DCH0: begin
            v = r.duty[0][9:2];
         end
         DPWM_OFS_DCH1: begin
            v = r.duty[1][9:2];
         end
         DPWM_OFS_DCL0: begin
            v = {r.duty[0][1:0], 6'h00};
         end
         DPWM_OFS_DCL1: begin
            v = {r.duty[1][1:0], 6'h00};
         end
         DPWM_OFS_TSEL: begin
            v = {4'h0, r.tsel};
         end
         default: begin
            v = 8'h00;
         end
      endcase
      read_mux = v;
   endfunction

   // one-hot register hit in map order: ctrl0, dch0, dcl0, ctrl1, dch1, dcl1, select
   function automatic logic [6:0] reg_decode(input logic [7:0] adr);
      logic [6:0] h;
      h = 7'h00;
      unique case (adr)
         DPWM_OFS_CTRL0: begin
            h[0] = 1'b1;
         end
         DPWM_OFS_DCH0: begin
            h[1] = 1'b1;
         end
         DPWM_OFS_DCL0: begin
            h[2] = 1'b1;
         end
         DPWM_OFS_CTRL1: begin
            h[3] = 1'b1;
         end
         DPWM_OFS_DCH1: begin
            h[4] = 1'b1;
         end
         DPWM_OFS_DCL1: begin
            h[5] = 1'b1;
         end
         DPWM_OFS_TSEL: begin
            h[6] = 1'b1;
         end
         default: begin
            h = 7'h00;
         end
      endcase
      reg_decode = h;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: answer one cycle after the request, commit writes on the edge that ends the answer
   always_comb begin
      req = wb_cyc_i & wb_stb_i;
      hit = reg_decode(wb_adr_i);
      mapped = |hit;
      commit = req & regs_reg.ack & wb_we_i & wb_sel_i[0] & mapped;
      rd_take = req & ~regs_reg.ack & ~wb_we_i; // reads only, so read data holds over writes
      wdat = wb_dat_i[7:0];
   end

   // register writes and read data capture
   always_comb begin
      regs_next = regs_reg;
      regs_next.ack = req & ~regs_reg.ack;
      if (rd_take) begin
         regs_next.dat = read_mux(wb_adr_i, regs_reg, out_level);
      end
      if (commit) begin
         unique case (wb_adr_i)
            DPWM_OFS_CTRL0: begin
               regs_next.en[0] = wdat[DPWM_CTRL_EN_BIT];
               regs_next.pol[0] = wdat[DPWM_CTRL_POL_BIT];
            end
            DPWM_OFS_CTRL1: begin
               regs_next.en[1] = wdat[DPWM_CTRL_EN_BIT];
               regs_next.pol[1] = wdat[DPWM_CTRL_POL_BIT];
            end
            DPWM_OFS_DCH0: begin
               regs_next.duty[0][9:2] = wdat;
            end
            DPWM_OFS_DCH1: begin
               regs_next.duty[1][9:2] = wdat;
            end
            DPWM_OFS_DCL0: begin
               regs_next.duty[0][1:0] = wdat[DPWM_DCL_LSB_POS +: 2];
            end
            DPWM_OFS_DCL1: begin
               regs_next.duty[1][1:0] = wdat[DPWM_DCL_LSB_POS +: 2];
            end
            DPWM_OFS_TSEL: begin
               regs_next.tsel = wdat[3:0];
            end
            default: begin
               regs_next.tsel = regs_reg.tsel;
            end
         endcase
      end
   end

   // register state
   always_ff @(posedge clock) begin
      if (reset) begin
         regs_reg.en <= 2'h0;
         regs_reg.pol <= 2'h0;
         regs_reg.duty <= {DPWM_DUTY_RESET, DPWM_DUTY_RESET};
         regs_reg.tsel <= DPWM_TSEL_RESET;
         regs_reg.ack <= 1'b0;
         regs_reg.dat <= 8'h00;
      end else begin
         regs_reg <= regs_next;
      end
   end

   assign wb_ack_o = regs_reg.ack;
   assign wb_dat_o = {24'h000000, regs_reg.dat};

   // timer select field of each channel
   always_comb begin
      chan_sel[0] = regs_reg.tsel[DPWM_TSEL_CH0_POS +: 2];
      chan_sel[1] = regs_reg.tsel[DPWM_TSEL_CH1_POS +: 2];
   end

   ////////////////////////////////////////////////////////////////////////////
   // channel engines
   dpwm_chan u_chan0 (
      .clock(clock),
      .reset(reset),
      .enable(regs_reg.en[0]),
      .polarity(regs_reg.pol[0]),
      .duty_value(regs_reg.duty[0]),
      .timer_sel(chan_sel[0]),
      .timer_count(timer_count),
      .timer_period(timer_period),
      .timer_phase(timer_phase),
      .timer_prescale(timer_prescale),
      .timer_is_1to1(timer_is_1to1),
      .timer_restart(timer_restart),
      .out_level(out_level[0]),
      .pwm_out(pwm_out[0])
   );

   dpwm_chan u_chan1 (
      .clock(clock),
      .reset(reset),
      .enable(regs_reg.en[1]),
      .polarity(regs_reg.pol[1]),
      .duty_value(regs_reg.duty[1]),
      .timer_sel(chan_sel[1]),
      .timer_count(timer_count),
      .timer_period(timer_period),
      .timer_phase(timer_phase),
      .timer_prescale(timer_prescale),
      .timer_is_1to1(timer_is_1to1),
      .timer_restart(timer_restart),
      .out_level(out_level[1]),
      .pwm_out(pwm_out[1])
   );

endmodule
`default_nettype wire

// [core/dpwm_pkg.sv]
// Contract
// - each channel has an 8-bit read/write duty high register holding duty value bits 9 to 2.
// - bits 7 and 6 of each channel's duty low register hold duty value bits 1 and 0, read/write.
// - bits 5 to 0 of the duty low register ignore writes and read as zero.
// - timer select bits 3:2 pick the second channel's timer: 01 first, 10 second, 11 third, 00 none.
// - timer select bits 1:0 pick the first channel's timer with the same encoding.
// - a written duty value is taken into use only when the selected timer restarts its period.
// - on the restart after a period match the output goes active, unless the duty value is zero or above the period length.
// - the 10-bit time base is the 8-bit count with two low bits from clock phase or prescaler.
// - a latched duty value above the period length leaves the output unchanged for that period.
package dpwm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets, one aligned word each
   localparam logic [7:0] DPWM_OFS_CTRL0 = 8'h00;
   localparam logic [7:0] DPWM_OFS_DCH0 = 8'h04;
   localparam logic [7:0] DPWM_OFS_DCL0 = 8'h08;
   localparam logic [7:0] DPWM_OFS_CTRL1 = 8'h0C;
   localparam logic [7:0] DPWM_OFS_DCH1 = 8'h10;
   localparam logic [7:0] DPWM_OFS_DCL1 = 8'h14;
   localparam logic [7:0] DPWM_OFS_TSEL = 8'h18;

   ////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int DPWM_CTRL_EN_BIT = 7;
   localparam int DPWM_CTRL_OUT_BIT = 5;
   localparam int DPWM_CTRL_POL_BIT = 4;
   localparam int DPWM_DCL_LSB_POS = 6;
   localparam int DPWM_TSEL_CH0_POS = 0;
   localparam int DPWM_TSEL_CH1_POS = 2;

   ////////////////////////////////////////////////////////////////////////////
   // reset values and encodings
   localparam logic [3:0] DPWM_TSEL_RESET = 4'h5;
   localparam logic [9:0] DPWM_DUTY_RESET = 10'h000;
   localparam logic [1:0] DPWM_TSEL_NONE = 2'h0;
   localparam logic [1:0] DPWM_TSEL_FIRST = 2'h1;
   localparam logic [1:0] DPWM_TSEL_SECOND = 2'h2;
   localparam logic [1:0] DPWM_TSEL_THIRD = 2'h3;
   localparam int DPWM_ACK_LATENCY = 1;

   ////////////////////////////////////////////////////////////////////////////
   // state types
   typedef struct packed {
      logic [9:0] duty_lat;
      logic level;
      logic pin;
   } dpwm_chan_state_t;

   typedef struct packed {
      logic [1:0] en;
      logic [1:0] pol;
      logic [1:0][9:0] duty;
      logic [3:0] tsel;
      logic ack;
      logic [7:0] dat;
   } dpwm_regs_state_t;

   // 10-bit time base from count and its two extension bits
   function automatic logic [9:0] dpwm_time_base(
      input logic [7:0] count,
      input logic [1:0] phase,
      input logic [1:0] pre,
      input logic one_to_one);
      dpwm_time_base = {count, (one_to_one ? phase : pre)};
   endfunction

   // period length in time base steps, 4 * (period + 1)
   function automatic logic [10:0] dpwm_period_len(input logic [7:0] period);
      dpwm_period_len = {({1'b0, period} + 9'h001), 2'h0};
   endfunction

endpackage

// [core/dpwm_chan.sv]
`timescale 1ns/10ps
`default_nettype none
module dpwm_chan
   import dpwm_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic enable,
   input wire logic polarity,
   input wire logic [9:0] duty_value,
   input wire logic [1:0] timer_sel,
   input wire logic [2:0][7:0] timer_count,
   input wire logic [2:0][7:0] timer_period,
   input wire logic [2:0][1:0] timer_phase,
   input wire logic [2:0][1:0] timer_prescale,
   input wire logic [2:0] timer_is_1to1,
   input wire logic [2:0] timer_restart,
   output logic out_level,
   output logic pwm_out
);

   dpwm_chan_state_t state_reg;
   dpwm_chan_state_t state_next;
   logic [1:0] idx;
   logic [9:0] time_base;
   logic restart;
   logic [10:0] per_len;
   logic sel_ok;

   ////////////////////////////////////////////////////////////////////////////
   // selected timer's view
   always_comb begin
      sel_ok = timer_sel != DPWM_TSEL_NONE;
      idx = sel_ok ? (timer_sel - 2'h1) : 2'h0; // reserved code kept inside the timer range
      time_base = dpwm_time_base(timer_count[idx], timer_phase[idx],
         timer_prescale[idx], timer_is_1to1[idx]);
      restart = sel_ok && timer_restart[idx];
      per_len = dpwm_period_len(timer_period[idx]);
   end

   // period start, compare and pin drive
   always_comb begin
      state_next = state_reg;
      if (restart) begin
         state_next.duty_lat = duty_value;
         if (duty_value == 10'h000) begin
            state_next.level = 1'b0;
         end else if ({1'b0, duty_value} > per_len) begin
            state_next.level = state_reg.level;
         end else begin
            state_next.level = 1'b1;
         end
      end else if (sel_ok && state_reg.level &&
         (time_base == (state_reg.duty_lat - 10'h001))) begin
         // one step early, so the registered pin drops as the time base reaches the duty
         state_next.level = 1'b0;
      end
      if (!enable) begin
         state_next.level = 1'b0;
      end
      state_next.pin = enable & (state_next.level ^ polarity);
   end

   // state register
   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign out_level = state_reg.level;
   assign pwm_out = state_reg.pin;

endmodule
`default_nettype wire

// [sim/dpwm_top_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module dpwm_monitor
   import dpwm_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [1:0] pwm_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   // read answer seen this cycle
   wire logic rd = wb_ack_o && !wb_we_i;
   sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence ans_s; wb_ack_o ##1 !wb_ack_o; endsequence
   ////////////////////////////////////////////////////////////////////////////
   chk_ack_one_pulse: assert property (req_s |=> ans_s) else $error("ack not one cycle later");
   chk_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   chk_dat_held: assert property (wb_ack_o |=> $stable(wb_dat_o)) else $error("read data moved");
   chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
      else $error("upper read bits set");
   chk_low_unused: assert property (rd && (wb_adr_i == DPWM_OFS_DCL0 ||
      wb_adr_i == DPWM_OFS_DCL1) |-> wb_dat_o[5:0] == 6'h00) else $error("low duty bits set");
   chk_tsel_unused: assert property (rd && wb_adr_i == DPWM_OFS_TSEL |->
      wb_dat_o[7:4] == 4'h0) else $error("select upper bits set");
   chk_unmapped_zero: assert property (rd && wb_adr_i == 8'h1C |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_reset_quiet: assert property (@(posedge clock) disable iff (1'b0)
      reset |=> !wb_ack_o && pwm_out == 2'h0) else $error("outputs active in reset");
endmodule
bind dpwm_top dpwm_monitor chk_u (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .pwm_out(pwm_out));
`default_nettype wire

// [sim/dpwm_timer_model.sv]
`timescale 1ns/10ps
`default_nettype none
module dpwm_timer_model #(
   parameter logic [2:0][7:0] PERIODS = {8'h02, 8'h03, 8'h01},
   parameter logic [2:0] ONE_TO_ONE = 3'b101
) (
   output logic [2:0][7:0] timer_count,
   output logic [2:0][7:0] timer_period,
   output logic [2:0][1:0] timer_phase,
   output logic [2:0][1:0] timer_prescale,
   output logic [2:0] timer_is_1to1,
   output logic [2:0] timer_restart,
   input wire logic clock,
   input wire logic reset
);
   logic [1:0] tick_reg;
   // unused extension source shows the inverse so a wrong pick is seen
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         timer_period[i] = PERIODS[i];
         timer_phase[i] = ONE_TO_ONE[i] ? tick_reg : ~tick_reg;
         timer_prescale[i] = ONE_TO_ONE[i] ? ~tick_reg : tick_reg;
         timer_restart[i] = tick_reg == 2'h3 && timer_count[i] == PERIODS[i];
      end
   end
   assign timer_is_1to1 = ONE_TO_ONE;
   // count steps every fourth clock and clears after a period match
   always_ff @(posedge clock) begin
      tick_reg <= reset ? 2'h0 : tick_reg + 2'h1;
      for (int i = 0; i < 3; i++) begin
         if (reset || timer_restart[i]) begin
            timer_count[i] <= 8'h00;
         end else if (tick_reg == 2'h3) begin
            timer_count[i] <= timer_count[i] + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// [sim/dual_pwm_duty_timer_select_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module dual_pwm_duty_timer_select_tb
   import dpwm_pkg::*;
;
   logic clock = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
   logic [7:0] adr = 8'h00, r;
   logic [3:0] sel = 4'hF;
   logic [31:0] dat = 32'h0, rdat;
   logic [1:0] pwm;
   logic [9:0] dv;
   logic [2:0][7:0] t_cnt, t_per;
   logic [2:0][1:0] t_ph, t_pre;
   logic [2:0] t_one, t_rst;
   logic [31:0] exp_q[$];
   int bad_count = 0, num_checks = 0, h0, l1;
   int duty[6] = '{8, 8, 16, 17, 0, 5};
   int want[6] = '{0, 24, 48, 48, 0, 15};
   always #5 clock = ~clock;
   dpwm_timer_model tmr_u (.clock(clock), .reset(reset), .timer_count(t_cnt),
      .timer_period(t_per), .timer_phase(t_ph), .timer_prescale(t_pre),
      .timer_is_1to1(t_one), .timer_restart(t_rst));
   dpwm_top dut_u (.clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .timer_count(t_cnt), .timer_period(t_per), .timer_phase(t_ph),
      .timer_prescale(t_pre), .timer_is_1to1(t_one), .timer_restart(t_rst), .pwm_out(pwm));
   ////////////////////////////////////////////////////////////////////////////
   task complete_run;
      if (bad_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   // one classic cycle, read expectation queued for the watcher
   task wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
      int n;
      n = 0;
      @(posedge clock);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, 24'h0, d};
      if (!w) exp_q.push_back({24'h0, e});
      do begin @(posedge clock); n++; end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin bad_count++; complete_run; end
      {cyc, stb} <= 2'b00;
   endtask
   task wait_rst(input int t);
      int n;
      n = 0;
      do begin @(posedge clock); n++; end while (t_rst[t] !== 1'b1 && n < 100);
      if (n >= 100) begin bad_count++; complete_run; end
   endtask
   // active cycles of both pins over a whole number of periods of every timer
   task count_out(output int hi, output int lo);
      hi = 0;
      lo = 0;
      repeat (48) begin
         @(posedge clock);
         hi += int'(pwm[0] === 1'b1);
         lo += int'(pwm[1] === 1'b0);
      end
   endtask
   // read data watcher
   always @(posedge clock) begin
      if (ack === 1'b1 && !we) check(rdat, exp_q.pop_front());
   end
   initial begin
      void'($urandom(51539));
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      wb(0, DPWM_OFS_TSEL, 0, 8'h05);
      for (int i = 0; i < 4; i++) begin
         r = 8'($urandom);
         wb(1, DPWM_OFS_DCH1, r, 0);
         wb(0, DPWM_OFS_DCH1, 0, r);
         wb(1, DPWM_OFS_DCL1, r, 0);
         wb(0, DPWM_OFS_DCL1, 0, r & 8'hC0);
         wb(1, DPWM_OFS_TSEL, {r[7:4], 2'(i), 2'(i)}, 0);
         wb(0, DPWM_OFS_TSEL, 0, {4'h0, 2'(i), 2'(i)});
      end
      wb(1, 8'h1C, 8'hFF, 0);
      wb(0, 8'h1C, 0, 8'h00);
      // a write with lane 0 disabled leaves the select unchanged
      sel <= 4'hE;
      wb(1, DPWM_OFS_TSEL, 8'h0A, 0);
      sel <= 4'hF;
      wb(0, DPWM_OFS_TSEL, 0, 8'h0F);
      // first channel on second timer, second on third timer, active low, duty 6
      wb(1, DPWM_OFS_TSEL, 8'h0E, 0);
      wb(1, DPWM_OFS_CTRL1, 8'h90, 0);
      wb(1, DPWM_OFS_DCH1, 8'h01, 0);
      wb(1, DPWM_OFS_DCL1, 8'h80, 0);
      for (int k = 0; k < 6; k++) begin
         if (k == 1) wb(1, DPWM_OFS_CTRL0, 8'h80, 0);
         dv = 10'(duty[k]);
         wb(1, DPWM_OFS_DCH0, dv[9:2], 0);
         wb(1, DPWM_OFS_DCL0, {dv[1:0], 6'($urandom)}, 0);
         wait_rst(1);
         wait_rst(1);
         count_out(h0, l1);
         check(32'(h0), 32'(want[k]));
         check(32'(l1), 32'd24);
      end
      // first channel on third timer, second on first timer
      wb(1, DPWM_OFS_TSEL, 8'h07, 0);
      wait_rst(2);
      wait_rst(2);
      count_out(h0, l1);
      check(32'(h0), 32'd20);
      check(32'(l1), 32'd36);
      // full period duty, then the reserved select holds the level
      wb(1, DPWM_OFS_DCH0, 8'h03, 0);
      wb(1, DPWM_OFS_DCL0, 8'h00, 0);
      wait_rst(2);
      wait_rst(2);
      wb(1, DPWM_OFS_TSEL, 8'h04, 0);
      wb(1, DPWM_OFS_DCH0, 8'h00, 0);
      wb(0, DPWM_OFS_CTRL0, 0, 8'hA0);
      count_out(h0, l1);
      check(32'(h0), 32'd48);
      check(32'(l1), 32'd36);
      complete_run;
   end
endmodule
`default_nettype wire
